/* src/fgl_top.sv */
// command gate of a serial NOR flash: write guards and read latency
// assumes SPI mode 0 on sclk_in, cs_n_in held low at least 150 ns per frame,
// and an array engine that pulses op_done_in when a program or erase ends
`timescale 1ns/1ps
`include "fgl_cfg.svh"
module fgl_top
    import fgl_pkg::*;
#(
    parameter int PUW_CYCLES = `FGL_PUW_US * `FGL_MCLK_MHZ
)
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic por_in,
    input wire logic wp_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic di_in,
    input wire logic op_done_in,
    output logic [7:0] first_status_out,
    output logic [7:0] second_status_out,
    output logic [7:0] third_status_out,
    output logic deep_sleep_out,
    output logic op_req_out,
    output fgl_op_e op_kind_out,
    output logic [21:0] op_addr_out,
    output logic cmd_drop_out,
    output logic [2:0] rd_mode_out,
    output logic [3:0] rd_dummy_out
);
    logic por_s;
    logic wp_s;
    logic cs_s;
    logic clr_reg;
    logic ran_reg;
    logic fresh_reg;
    logic [2:0] bit_pos_reg;
    logic [2:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] opc_reg;
    logic [23:0] addr_reg;
    logic [7:0] tsr_reg;

    fgl_sync #(.W(3), .RST_VAL(3'b111)) u_sync (
        .clk_in(mclk_in),
        .rstn_in(rstn_in),
        .d_in({por_in, wp_n_in, cs_n_in}),
        .q_out({por_s, wp_s, cs_s})
    );

    // link side: restarts at the frame's first edge, armed by the deselect before the frame
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            fresh_reg <= 1'b1;
        else
            fresh_reg <= 1'b0;
    end

    // marks that the link clocked this frame; mclk side clears it while idle
    always_ff @(posedge sclk_in or posedge clr_reg)
    begin
        if (clr_reg)
            ran_reg <= 1'b0;
        else
            ran_reg <= 1'b1;
    end

    wire [2:0] bit_pos_cur = fresh_reg ? 3'h0 : bit_pos_reg;
    wire [2:0] byte_cnt_cur = fresh_reg ? 3'h0 : byte_cnt_reg;
    wire [7:0] byte_done = {shift_reg[6:0], di_in};
    wire byte_end = bit_pos_cur == 3'h7;
    wire [2:0] byte_cnt_next = (byte_end && byte_cnt_cur != 3'h7) ?
        byte_cnt_cur + 3'h1 : byte_cnt_cur;

    always_ff @(posedge sclk_in)
    begin
        bit_pos_reg <= bit_pos_cur + 3'h1;
        byte_cnt_reg <= byte_cnt_next;
        shift_reg <= byte_done;
        if (byte_end && byte_cnt_cur == 3'h0)
            opc_reg <= byte_done;
        if (byte_end && byte_cnt_cur == 3'h1)
            addr_reg[23:16] <= byte_done;
        if (byte_end && byte_cnt_cur == 3'h2)
            addr_reg[15:8] <= byte_done;
        if (byte_end && byte_cnt_cur == 3'h3)
            addr_reg[7:0] <= byte_done;
    end

    // latency code is changed only between frames, so it is static while the link runs
    wire [3:0] lat_code = tsr_reg[`FGL_TSR_LAT_HI:0];
    wire legacy = lat_code == 4'h0;
    wire is_read = byte_done == `FGL_OPC_READ;
    wire is_fast = byte_done == `FGL_OPC_FREAD || byte_done == `FGL_OPC_DOREAD ||
        byte_done == `FGL_OPC_QOREAD;
    wire is_dio = byte_done == `FGL_OPC_DIOREAD;
    wire is_qio = byte_done == `FGL_OPC_QIOREAD;
    wire is_wqio = byte_done == `FGL_OPC_WQIOREAD;
    wire [3:0] dummy_next = is_read ? 4'h0 :
        is_fast ? (legacy ? `FGL_LEGACY_DUMMY : lat_code) :
        is_dio ? (legacy ? 4'h0 : lat_code) :
        is_qio ? (legacy ? `FGL_QIO_DUMMY : lat_code) :
        is_wqio ? (legacy ? `FGL_WQIO_DUMMY : lat_code) : 4'h0;
    wire [2:0] mode_next = is_dio ? `FGL_DIO_MODE : (is_qio || is_wqio) ? `FGL_QIO_MODE : 3'h0;

    // figures for the read datapath, valid from the edge after the opcode
    always_ff @(posedge sclk_in)
    begin
        if (byte_end && byte_cnt_cur == 3'h0)
        begin
            rd_dummy_out <= dummy_next;
            rd_mode_out <= mode_next;
        end
    end

    // controller side
    logic cs_prev_reg;
    logic [15:0] puw_cnt_reg;
    logic wel_reg;
    logic busy_reg;
    logic vol_en_reg;
    logic rst_en_reg;
    logic deep_sleep_reg;
    logic [5:0] fsr_nv_reg;
    logic srp_hi_reg;
    logic qe_reg;
    logic inv_reg;
    logic op_req_reg;

    fgl_prot_if prot_bus ();
    fgl_prot_chk u_prot (.prot(prot_bus));

    wire frame_go = cs_s && !cs_prev_reg && ran_reg;
    wire whole = bit_pos_reg == 3'h0;
    wire puw_active = puw_cnt_reg != 16'h0000;
    wire accept = frame_go && !por_s && !deep_sleep_reg && !busy_reg && whole;
    wire [1:0] srp = {srp_hi_reg, fsr_nv_reg[`FGL_FSR_MODE_LO - 2]};
    wire hw_lock = srp == 2'b01 && !wp_s && !qe_reg;
    wire sr_locked = hw_lock || srp[1];
    wire can_write = wel_reg || vol_en_reg;

    wire opc_erase = opc_reg == `FGL_OPC_SE || opc_reg == `FGL_OPC_BE32 ||
        opc_reg == `FGL_OPC_BE64;
    wire opc_chip = opc_reg == `FGL_OPC_CE || opc_reg == `FGL_OPC_CE2;
    wire opc_pp = opc_reg == `FGL_OPC_PP;
    wire opc_wrsr = opc_reg == `FGL_OPC_WRSR;
    wire opc_wrsr3 = opc_reg == `FGL_OPC_WRSR3;
    wire write_class = opc_erase || opc_chip || opc_pp || opc_wrsr || opc_wrsr3 ||
        opc_reg == `FGL_OPC_WREN;
    wire long_enough = opc_pp ? byte_cnt_reg >= `FGL_PP_BYTES :
        opc_erase ? byte_cnt_reg >= `FGL_ERASE_BYTES : 1'b1;

    assign prot_bus.gran_sel = fsr_nv_reg[`FGL_FSR_GRAN - 2];
    assign prot_bus.topbot_sel = fsr_nv_reg[`FGL_FSR_TOPBOT - 2];
    assign prot_bus.protect_size = fsr_nv_reg[`FGL_FSR_SIZE_HI - 2:0];
    assign prot_bus.invert = inv_reg;
    assign prot_bus.sector_idx = addr_reg[21:12];
    assign prot_bus.kind = opc_pp ? fgl_op_page :
        (opc_reg == `FGL_OPC_SE) ? fgl_op_sect :
        (opc_reg == `FGL_OPC_BE32) ? fgl_op_blk32 :
        (opc_reg == `FGL_OPC_BE64) ? fgl_op_blk64 : fgl_op_chip;

    wire do_wren = accept && !puw_active && opc_reg == `FGL_OPC_WREN;
    wire do_wrdi = accept && opc_reg == `FGL_OPC_WRDI;
    wire do_vwren = accept && opc_reg == `FGL_OPC_VWREN;
    wire do_op = accept && !puw_active && wel_reg && (opc_pp || opc_erase || opc_chip) &&
        long_enough && !prot_bus.hit;
    wire do_wrsr = accept && !puw_active && opc_wrsr && can_write && !sr_locked &&
        byte_cnt_reg >= `FGL_WRSR_BYTES;
    wire do_wrsr2 = do_wrsr && byte_cnt_reg >= `FGL_WRSR_FULL;
    wire do_wrsr3 = accept && !puw_active && opc_wrsr3 && can_write &&
        byte_cnt_reg >= `FGL_WRSR_BYTES;
    wire do_sleep = accept && opc_reg == `FGL_OPC_SLEEP;
    wire do_wake = frame_go && !por_s && deep_sleep_reg && opc_reg == `FGL_OPC_WAKE;
    wire do_rst = accept && rst_en_reg && opc_reg == `FGL_OPC_RST;
    wire done_now = busy_reg && op_done_in;
    wire wel_clear = do_wrdi || done_now || do_wrsr || do_wrsr3 || do_rst;

    // power-up delay restarts whenever the supply monitor holds reset
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in || por_s)
            puw_cnt_reg <= 16'(PUW_CYCLES);
        else if (puw_active)
            puw_cnt_reg <= puw_cnt_reg - 16'h0001;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in || por_s)
        begin
            cs_prev_reg <= 1'b1;
            clr_reg <= 1'b1;
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            vol_en_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            deep_sleep_reg <= 1'b0;
            op_req_reg <= 1'b0;
        end
        else
        begin
            cs_prev_reg <= cs_s;
            clr_reg <= cs_s;
            if (do_wren)
                wel_reg <= 1'b1;
            else if (wel_clear)
                wel_reg <= 1'b0;
            busy_reg <= do_op || (busy_reg && !op_done_in);
            if (frame_go && !deep_sleep_reg)
                vol_en_reg <= do_vwren;
            if (frame_go && !deep_sleep_reg)
                rst_en_reg <= accept && opc_reg == `FGL_OPC_RSTEN;
            if (do_sleep)
                deep_sleep_reg <= 1'b1;
            else if (do_wake)
                deep_sleep_reg <= 1'b0;
            op_req_reg <= do_op;
        end
    end

    // protection bits; lock-down falls back to software mode on power-up or soft reset
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            fsr_nv_reg <= 6'(`FGL_SR_RST);
            srp_hi_reg <= 1'b0;
            qe_reg <= 1'b0;
            inv_reg <= 1'b0;
            tsr_reg <= `FGL_SR_RST;
        end
        else if ((por_s || do_rst) && srp == 2'b10)
        begin
            srp_hi_reg <= 1'b0;
            fsr_nv_reg[`FGL_FSR_MODE_LO - 2] <= 1'b0;
            tsr_reg <= `FGL_SR_RST;
        end
        else if (por_s || do_rst)
            tsr_reg <= `FGL_SR_RST;
        else
        begin
            if (do_wrsr)
                fsr_nv_reg <= addr_reg[23:18];
            if (do_wrsr2)
            begin
                srp_hi_reg <= addr_reg[8 + `FGL_SSR_MODE_HI];
                qe_reg <= addr_reg[8 + `FGL_SSR_QUAD];
                inv_reg <= addr_reg[8 + `FGL_SSR_INV];
            end
            if (do_wrsr3)
                tsr_reg <= addr_reg[23:16];
        end
    end

    // status and request outputs, all from flops
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            first_status_out <= `FGL_SR_RST;
            second_status_out <= `FGL_SR_RST;
            third_status_out <= `FGL_SR_RST;
            deep_sleep_out <= 1'b0;
            op_req_out <= 1'b0;
            op_kind_out <= fgl_op_page;
            op_addr_out <= 22'h000000;
            cmd_drop_out <= 1'b0;
        end
        else
        begin
            first_status_out <= {fsr_nv_reg, wel_reg, busy_reg};
            second_status_out <= {1'b0, inv_reg, 4'h0, qe_reg, srp_hi_reg};
            third_status_out <= tsr_reg;
            deep_sleep_out <= deep_sleep_reg;
            op_req_out <= op_req_reg;
            if (do_op)
            begin
                op_kind_out <= prot_bus.kind;
                op_addr_out <= addr_reg[21:0];
            end
            cmd_drop_out <= frame_go && write_class && !(do_wren || do_op || do_wrsr ||
                do_wrsr3);
        end
    end

    a_legacy_dummy: assert property (@(posedge sclk_in) disable iff (cs_n_in)
        (byte_end && byte_cnt_cur == 3'h0 && is_fast && legacy) |=>
        rd_dummy_out == `FGL_LEGACY_DUMMY)
        else $error("legacy fast read dummy count wrong");
    a_plain_read: assert property (@(posedge sclk_in) disable iff (cs_n_in)
        (byte_end && byte_cnt_cur == 3'h0 && is_read) |=> rd_dummy_out == 4'h0)
        else $error("plain read picked up latency");
    a_por_blocks: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        por_s |=> !op_req_reg && !wel_reg && !deep_sleep_reg)
        else $error("activity during power-on reset");
    a_puw_no_latch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (puw_active && !wel_reg) |=> !wel_reg)
        else $error("latch set inside power-up delay");
    a_puw_length: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $fell(por_s) |-> puw_cnt_reg == 16'(PUW_CYCLES))
        else $error("power-up delay not reloaded");
    a_req_needs_latch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        op_req_reg |-> $past(wel_reg) && busy_reg)
        else $error("operation without write enable");
    a_done_clears: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (busy_reg && op_done_in && !do_wren) |=> !wel_reg && !busy_reg ##1 !first_status_out[1])
        else $error("completion left latch set");
    a_byte_boundary: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (frame_go && !whole) |=> !op_req_reg && $stable(fsr_nv_reg) && $stable(tsr_reg))
        else $error("partial byte frame executed");
    a_sleep_filter: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (frame_go && !por_s && deep_sleep_reg && opc_reg != `FGL_OPC_WAKE) |=>
        deep_sleep_reg && !op_req_reg && $stable(wel_reg))
        else $error("command honoured in deep sleep");
    a_hw_lock: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (frame_go && hw_lock && !por_s) |=> $stable(fsr_nv_reg) && $stable(srp_hi_reg))
        else $error("status written while pin locked");
    a_prot_block: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        op_req_reg |-> !$past(prot_bus.hit))
        else $error("protected region targeted");
endmodule

/* shared/fgl_cfg.svh */
// constants for the flash write guard and read latency block
// included by the command gate and the protected-region checker
`ifndef FGL_CFG_SVH
`define FGL_CFG_SVH

`define FGL_MCLK_MHZ 40
`define FGL_PUW_US 1000

`define FGL_OPC_WREN 8'h06
`define FGL_OPC_WRDI 8'h04
`define FGL_OPC_VWREN 8'h50
`define FGL_OPC_WRSR 8'h01
`define FGL_OPC_WRSR3 8'h11
`define FGL_OPC_PP 8'h02
`define FGL_OPC_SE 8'h20
`define FGL_OPC_BE32 8'h52
`define FGL_OPC_BE64 8'hD8
`define FGL_OPC_CE 8'hC7
`define FGL_OPC_CE2 8'h60
`define FGL_OPC_SLEEP 8'hB9
`define FGL_OPC_WAKE 8'hAB
`define FGL_OPC_RSTEN 8'h66
`define FGL_OPC_RST 8'h99
`define FGL_OPC_READ 8'h03
`define FGL_OPC_FREAD 8'h0B
`define FGL_OPC_DOREAD 8'h3B
`define FGL_OPC_DIOREAD 8'hBB
`define FGL_OPC_QOREAD 8'h6B
`define FGL_OPC_QIOREAD 8'hEB
`define FGL_OPC_WQIOREAD 8'hE7

`define FGL_FSR_BUSY 0
`define FGL_FSR_LATCH 1
`define FGL_FSR_SIZE_LO 2
`define FGL_FSR_SIZE_HI 4
`define FGL_FSR_TOPBOT 5
`define FGL_FSR_GRAN 6
`define FGL_FSR_MODE_LO 7
`define FGL_SSR_MODE_HI 0
`define FGL_SSR_QUAD 1
`define FGL_SSR_INV 6
`define FGL_TSR_LAT_HI 3
`define FGL_SR_RST 8'h00

`define FGL_LEGACY_DUMMY 4'h8
`define FGL_DIO_MODE 3'h4
`define FGL_QIO_MODE 3'h2
`define FGL_QIO_DUMMY 4'h4
`define FGL_WQIO_DUMMY 4'h2

`define FGL_SECTORS 11'h400
`define FGL_BLK64_SECT 11'h010
`define FGL_BLK32_SECT 11'h008
`define FGL_GRAN_CAP 11'h008

`define FGL_PP_BYTES 3'h5
`define FGL_ERASE_BYTES 3'h4
`define FGL_WRSR_BYTES 3'h2
`define FGL_WRSR_FULL 3'h3

`endif

/* shared/fgl_pkg.sv */
// types shared by the write guard modules
// assumes nothing beyond the constants header
package fgl_pkg;
    typedef enum logic [2:0] {fgl_op_page, fgl_op_sect, fgl_op_blk32, fgl_op_blk64,
        fgl_op_chip} fgl_op_e;
endpackage

/* shared/fgl_prot_if.sv */
// carrier between the command gate and the protected-region checker
// assumes the package is compiled first
`timescale 1ns/1ps
interface fgl_prot_if;
    import fgl_pkg::*;
    logic gran_sel;
    logic topbot_sel;
    logic [2:0] protect_size;
    logic invert;
    logic [9:0] sector_idx;
    fgl_op_e kind;
    logic hit;
    modport chk (input gran_sel, topbot_sel, protect_size, invert, sector_idx, kind,
        output hit);
    modport req (output gran_sel, topbot_sel, protect_size, invert, sector_idx, kind,
        input hit);
endinterface

/* src/fgl_sync.sv */
// three-stage synchroniser for levels from pins
// assumes a synchronous active-low reset in the destination domain
`timescale 1ns/1ps
module fgl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // a bit changes only once stages two and three agree
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [W-1:0] q_next = (agree & s3_reg) | (~agree & q_out);

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_out <= RST_VAL;
        end
        else
        begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_out <= q_next;
        end
    end
endmodule

/* src/fgl_prot_chk.sv */
// decides whether an erase or program target touches the read-only region
// assumes 1024 sectors of 4 kB, 64 blocks of 64 kB; purely combinational
`timescale 1ns/1ps
`include "fgl_cfg.svh"
module fgl_prot_chk
    import fgl_pkg::*;
(
    fgl_prot_if.chk prot
);
    wire [2:0] shift = prot.protect_size - 3'h1;
    wire [10:0] blk_n = `FGL_BLK64_SECT << shift;
    wire [10:0] one_n = 11'h001 << shift;
    wire [10:0] gran_n = (one_n > `FGL_GRAN_CAP) ? `FGL_GRAN_CAP : one_n;
    // protected sector count before complement, smallest one 4 kB sector
    wire [10:0] prot_n = (prot.protect_size == 3'h0) ? 11'h000 :
        (prot.protect_size == 3'h7) ? `FGL_SECTORS :
        prot.gran_sel ? gran_n : blk_n;
    wire [10:0] span = (prot.kind == fgl_op_blk64) ? `FGL_BLK64_SECT :
        (prot.kind == fgl_op_blk32) ? `FGL_BLK32_SECT :
        (prot.kind == fgl_op_chip) ? `FGL_SECTORS : 11'h001;
    wire [10:0] t_lo = {1'b0, prot.sector_idx} & ~(span - 11'h001);
    wire [10:0] t_hi = t_lo + span - 11'h001;
    wire [10:0] top_edge = `FGL_SECTORS - prot_n;
    wire hit_plain = prot.topbot_sel ? (t_lo < prot_n) : (t_hi >= top_edge);
    wire hit_inv = prot.topbot_sel ? (t_hi >= prot_n) : (t_lo < top_edge);

    assign prot.hit = prot.invert ? hit_inv : hit_plain;
endmodule

/* tb/fgl_spi_host.sv */
// host side of the serial link: sends mode 0 frames, msb first
// assumes the bench calls send() and leaves time between frames
`timescale 1ns/1ps
module fgl_spi_host
(
    output logic sclk_out,
    output logic cs_n_out,
    output logic di_out
);
    logic lclk = 1'b0;
    logic en = 1'b0;

    initial
    begin
        cs_n_out = 1'b1;
        di_out = 1'b1;
        #0.7;
        forever #3 lclk = ~lclk;
    end

    // link clock is gated so it stands still outside frames
    assign sclk_out = lclk & en;

    // data sits left aligned; n bits go out, a whole byte count unless a test wants otherwise
    task automatic send(input logic [63:0] d, input int n);
        int i;
        cs_n_out = 1'b0;
        #160;
        for (i = 0; i < n; i++)
        begin
            @(negedge lclk);
            di_out = d[63-i];
            en = 1'b1;
        end
        @(negedge lclk);
        en = 1'b0;
        // released data line shows the inverse of the last bit
        di_out = ~di_out;
        #160;
        cs_n_out = 1'b1;
        #200;
    endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the flash write guard and read latency block
// assumes the host model in fgl_spi_host.sv and a short power-up delay
`timescale 1ns/1ps
module testbench;
    import fgl_pkg::*;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic por_in = 1'b0;
    logic wp_n_in = 1'b1;
    logic op_done_in = 1'b0;
    wire sclk_in;
    wire cs_n_in;
    wire di_in;
    logic [7:0] first_status_out;
    logic [7:0] second_status_out;
    logic [7:0] third_status_out;
    logic deep_sleep_out;
    logic op_req_out;
    fgl_op_e op_kind_out;
    logic [21:0] op_addr_out;
    logic cmd_drop_out;
    logic [2:0] rd_mode_out;
    logic [3:0] rd_dummy_out;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int req_cnt = 0;
    int drop_cnt = 0;
    integer seed = 32'h69c8;
    logic [3:0] code;
    logic [9:0] sect;
    logic [7:0] rd_ops [7] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7};
    logic [3:0] codes [4];

    always #12.5 mclk_in = ~mclk_in;

    fgl_spi_host host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .di_out(di_in));

    fgl_top #(.PUW_CYCLES(40)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .por_in(por_in),
        .wp_n_in(wp_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .di_in(di_in),
        .op_done_in(op_done_in), .first_status_out(first_status_out),
        .second_status_out(second_status_out), .third_status_out(third_status_out),
        .deep_sleep_out(deep_sleep_out), .op_req_out(op_req_out), .op_kind_out(op_kind_out),
        .op_addr_out(op_addr_out), .cmd_drop_out(cmd_drop_out), .rd_mode_out(rd_mode_out),
        .rd_dummy_out(rd_dummy_out));

    always @(posedge mclk_in)
    begin
        cycles <= cycles + 1;
        if (op_req_out === 1'b1)
            req_cnt <= req_cnt + 1;
        if (cmd_drop_out === 1'b1)
            drop_cnt <= drop_cnt + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one frame, then the launch and drop pulses it caused; ndrop below zero skips that count
    task automatic xfer(input logic [63:0] d, input int n, input int nreq, input int ndrop);
        int r0;
        int k0;
        r0 = req_cnt;
        k0 = drop_cnt;
        host.send(d, n);
        repeat (4) @(negedge mclk_in);
        check("launch pulses", req_cnt - r0, nreq);
        if (ndrop >= 0)
            check("drop pulses", drop_cnt - k0, ndrop);
    endtask

    task automatic finish_op;
        @(negedge mclk_in);
        op_done_in = 1'b1;
        @(negedge mclk_in);
        op_done_in = 1'b0;
        repeat (4) @(negedge mclk_in);
    endtask

    function automatic logic [6:0] lat_exp(input logic [7:0] op, input logic [3:0] c);
        case (op)
            8'h0B, 8'h3B, 8'h6B: return {3'h0, (c == 4'h0) ? 4'h8 : c};
            8'hBB: return {3'h4, c};
            8'hEB: return {3'h2, (c == 4'h0) ? 4'h4 : c};
            8'hE7: return {3'h2, (c == 4'h0) ? 4'h2 : c};
            default: return 7'h00;
        endcase
    endfunction

    initial
    begin
        repeat (20) @(negedge mclk_in);
        rstn_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("third status", third_status_out, 8'h00);
        check("first status", first_status_out, 8'h00);
        por_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        xfer({8'h06, 56'h0}, 8, 0, -1);
        check("latch in reset", first_status_out[1], 1'b0);
        por_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        xfer({8'h06, 56'h0}, 8, 0, 1);
        check("latch in delay", first_status_out[1], 1'b0);
        repeat (60) @(negedge mclk_in);
        xfer({8'h02, 24'h001000, 16'hA55A, 16'h0}, 40, 0, 1);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        check("latch set", first_status_out[1], 1'b1);
        xfer({8'h20, 24'h3FF000, 32'h0}, 31, 0, 1);
        check("latch kept", first_status_out[1], 1'b1);
        sect = $random(seed);
        xfer({8'h20, 2'h0, sect, 12'h000, 32'h0}, 32, 1, 0);
        check("kind", op_kind_out, fgl_op_sect);
        check("address", op_addr_out, {sect, 12'h000});
        check("busy", first_status_out[0], 1'b1);
        finish_op();
        check("latch after erase", first_status_out[1:0], 2'h0);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h47, 48'h0}, 16, 0, 0);
        check("status write", first_status_out, 8'h44);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h20, 24'h3FF000, 32'h0}, 32, 0, 1);
        xfer({8'hD8, 24'h3F0000, 32'h0}, 32, 0, 1);
        xfer({8'h20, 24'h3FE000, 32'h0}, 32, 1, 0);
        finish_op();
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h80, 48'h0}, 16, 0, 0);
        wp_n_in = 1'b0;
        repeat (6) @(negedge mclk_in);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h00, 48'h0}, 16, 0, 1);
        check("locked status", first_status_out[7], 1'b1);
        wp_n_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h00, 48'h0}, 16, 0, 0);
        check("unlocked status", first_status_out, 8'h00);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h00, 8'h41, 40'h0}, 24, 0, 0);
        check("second status", second_status_out, 8'h41);
        xfer({8'h06, 56'h0}, 8, 0, 0);
        xfer({8'h01, 8'h00, 48'h0}, 16, 0, 1);
        xfer({8'h66, 56'h0}, 8, 0, 0);
        xfer({8'h99, 56'h0}, 8, 0, 0);
        check("lock released", second_status_out, 8'h40);
        check("latch after soft reset", first_status_out[1], 1'b0);
        codes[0] = 4'h0;
        codes[1] = 4'h1;
        codes[2] = 4'hF;
        codes[3] = $random(seed);
        foreach (codes[j])
        begin
            code = codes[j];
            xfer({8'h50, 56'h0}, 8, 0, 0);
            xfer({8'h11, 4'h0, code, 48'h0}, 16, 0, 0);
            check("latency code", third_status_out[3:0], code);
            foreach (rd_ops[k])
            begin
                xfer({rd_ops[k], 56'h0}, 16, 0, 0);
                check("read clocks", {rd_mode_out, rd_dummy_out}, lat_exp(rd_ops[k], code));
            end
        end
        xfer({8'hB9, 56'h0}, 8, 0, 0);
        check("sleep", deep_sleep_out, 1'b1);
        xfer({8'h06, 56'h0}, 8, 0, 1);
        check("latch in sleep", first_status_out[1], 1'b0);
        xfer({8'hAB, 56'h0}, 8, 0, 0);
        check("woken", deep_sleep_out, 1'b0);
        close_out();
    end
endmodule
